// *** bcms_params.svh ***
`ifndef BCMS_PARAMS_SVH
`define BCMS_PARAMS_SVH
// Command block word offsets
`define BCMS_OFS_CTL 16'h0001
`define BCMS_OFS_CMD1 16'h0002
`define BCMS_OFS_CMD2 16'h0003
`define BCMS_OFS_PTR 16'h0004
`define BCMS_OFS_STS1 16'h0005
`define BCMS_OFS_STS2 16'h0006
`define BCMS_OFS_TAIL 16'h0007
// Control, command and status word fields
`define BCMS_CTL_ME 15
`define BCMS_CTL_SKIP 14
`define BCMS_CTL_INTC 13
`define BCMS_CTL_POLL 12
`define BCMS_CTL_RETRY 11
`define BCMS_CTL_EOL 10
`define BCMS_CTL_RTRT 9
`define BCMS_CTL_MON 8
`define BCMS_CMD_TR 10
`define BCMS_STS_ME 10
// Interrupt status bits
`define BCMS_HP_EOL 0
`define BCMS_HP_ME 1
`define BCMS_HP_STD 2
`define BCMS_ISW_INTC 0
`define BCMS_ISW_POLL 1
`define BCMS_ISW_ME 2
// Word sync patterns
`define BCMS_SYNC_CMD 3'h7
`define BCMS_SYNC_DAT 3'h0
// Timing
`define BCMS_CLK_NS 20
`define BCMS_STEP_NS 16000
`define BCMS_GAP_NS 4000
`define BCMS_TMO_NS 14000
`define BCMS_BIT_NS 1000
`define BCMS_STEP_CYC (`BCMS_STEP_NS / `BCMS_CLK_NS)
`define BCMS_GAP_CYC ((`BCMS_GAP_NS + `BCMS_CLK_NS - 1) / `BCMS_CLK_NS)
`define BCMS_TMO_CYC (`BCMS_TMO_NS / `BCMS_CLK_NS)
`define BCMS_BIT_CYC (`BCMS_BIT_NS / `BCMS_CLK_NS)
`endif

// *** bcms_pkg.sv ***
package bcms_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_F_CTL = 5'h01, S_F_CMD1 = 5'h03, S_F_PTR = 5'h02,
    S_TX_CMD1 = 5'h06, S_F_CMD2 = 5'h07, S_TX_CMD2 = 5'h05,
    S_TX_DATA = 5'h04, S_RX_STAT = 5'h0c, S_W_STAT = 5'h0d,
    S_RX_DATA = 5'h0f, S_W_DATA = 5'h0e, S_POST = 5'h0a,
    S_HP_HOLD = 5'h0b, S_LOG_ISW = 5'h09, S_LOG_PTR = 5'h08,
    S_LOG_TAIL = 5'h18, S_DELAY = 5'h19, S_WB_CTL = 5'h1b,
    S_RD_TAIL = 5'h1a, S_DMA_HOLD = 5'h1e
  } bcms_state_e;
  typedef struct packed {
    logic req;
    logic stb;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bcms_dma_s;
  typedef struct packed {
    logic valid;
    logic err;
    logic cmd_sync;
    logic [15:0] word;
  } bcms_rxw_s;
  typedef struct packed {
    bcms_state_e state;
    bcms_dma_s dma;
    logic busy;
    logic [15:0] ctl;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic [15:0] dptr;
    logic [15:0] cur_blk;
    logic [15:0] log_ptr;
    logic [15:0] buf_w;
    logic [15:0] rxd;
    logic [15:0] tx_word;
    logic buf_vld;
    logic txw;
    logic tx_start;
    logic tx_cmd;
    logic [5:0] cnt;
    logic [5:0] fcnt;
    logic phase;
    logic err;
    logic me;
    logic retry;
    logic bus;
    logic [2:0] rtry;
    logic [2:0] isw;
    logic [2:0] hp;
    logic hp_n;
    logic pls_n;
    logic lvl_n;
    logic [17:0] dly;
    logic [7:0] gap;
    logic [9:0] tmo;
  } bcms_seq_s;
endpackage : bcms_pkg

// *** bcms_codec.sv ***
`timescale 1ns/1ns
`include "bcms_params.svh"
module bcms_codec
  import bcms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_start,
  input wire logic [15:0] tx_word,
  input wire logic tx_cmd,
  input wire logic rx_bit,
  input wire logic rx_act,
  output logic tx_bit,
  output logic tx_en,
  output logic tx_done,
  output bcms_rxw_s rx
);
  logic [5:0] div_r, div_nxt;
  logic [19:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
  logic [4:0] tn_r, tn_nxt, rn_r, rn_nxt;
  logic bit_r, bit_nxt, en_r, en_nxt, done_r, done_nxt;
  bcms_rxw_s rx_r, rx_nxt;
  logic ben;

  // Bit rate is a one-cycle enable, not a second clock
  always_comb begin
    ben = (div_r == 6'(`BCMS_BIT_CYC - 1));
    div_nxt = ben ? 6'h00 : div_r + 6'h01;
    tsh_nxt = tsh_r;
    tn_nxt = tn_r;
    bit_nxt = bit_r;
    en_nxt = en_r;
    done_nxt = 1'b0;
    rsh_nxt = rsh_r;
    rn_nxt = rn_r;
    rx_nxt = rx_r;
    rx_nxt.valid = 1'b0;
    if (tx_start && !en_r) begin
      tsh_nxt = {(tx_cmd ? `BCMS_SYNC_CMD : `BCMS_SYNC_DAT), tx_word,
                 ~^tx_word};
      tn_nxt = 5'h14;
      en_nxt = 1'b1;
    end else if (ben && en_r) begin
      if (tn_r != 5'h00) begin
        bit_nxt = tsh_r[19];
        tsh_nxt = {tsh_r[18:0], 1'b0};
        tn_nxt = tn_r - 5'h01;
      end else begin
        en_nxt = 1'b0;
        bit_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
    // Word sync and parity judged here, the sequencer sees only results
    if (!rx_act) begin
      rn_nxt = 5'h00;
    end else if (ben) begin
      rsh_nxt = {rsh_r[18:0], rx_bit};
      rn_nxt = rn_r + 5'h01;
      if (rn_r == 5'h13) begin
        rn_nxt = 5'h00;
        rx_nxt.valid = 1'b1;
        rx_nxt.word = rsh_r[15:0];
        rx_nxt.cmd_sync = (rsh_r[18:16] == `BCMS_SYNC_CMD);
        rx_nxt.err = (~^{rsh_r[15:0], rx_bit}) |
          ((rsh_r[18:16] != `BCMS_SYNC_CMD) &&
           (rsh_r[18:16] != `BCMS_SYNC_DAT));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= 6'h00;
      tsh_r <= 20'h00000;
      tn_r <= 5'h00;
      bit_r <= 1'b0;
      en_r <= 1'b0;
      done_r <= 1'b0;
      rsh_r <= 20'h00000;
      rn_r <= 5'h00;
      rx_r <= '0;
    end else begin
      div_r <= div_nxt;
      tsh_r <= tsh_nxt;
      tn_r <= tn_nxt;
      bit_r <= bit_nxt;
      en_r <= en_nxt;
      done_r <= done_nxt;
      rsh_r <= rsh_nxt;
      rn_r <= rn_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign tx_bit = bit_r;
  assign tx_en = en_r;
  assign tx_done = done_r;
  assign rx = rx_r;
endmodule : bcms_codec

// *** bcms_sequencer.sv ***
`timescale 1ns/1ns
`include "bcms_params.svh"
// Functional notes
// [R1] Received status address must equal commanded address, else error.
// [R2] Flag response timeout, bad words, and malformed RT-RT blocks.
// [R3] Host starts operation by a start write after setting up blocks.
// [R4] After start, burst-read control word, command one, data pointer.
// [R5] BC-RT: read each data word at incrementing pointer and send it.
// [R6] Store single-RT status word at block offset five.
// [R7] RT-BC: store status first, then data at incrementing addresses.
// [R8] RT-RT: send command one, fetch command two at offset three, send.
// [R9] RT-RT data stored only when monitor option set.
// [R10] RT-RT second status stored at block offset six.
// [R11] High-priority interrupt if enabled; message error holds until cleared.
// [R12] Standard interrupt logs word and pointer, reads tail, pulses, continues.
// [R13] Retry re-fetches the block head words and repeats the message.
// [R14] Clean block: tail read, hold cycle, next block fetch in one burst.
// [R15] Errored block: control word written back before tail read.
// [R16] End-of-list block: stop and wait for a new start.
// [R17] Tail pointer becomes the current block address.
// [R18] Delay timer starts with message start, retries included; code loads it on the first attempt only, not on retries.
// [R19] Next data word is fetched while the current one transmits.
// [R20] Message error flag set even when a later retry succeeds.
// [R21] Retry reuses the same data addresses.
// [R22] End of list with poll match gives both interrupts.
// [R23] Delay field counts 16 us steps; zero off; minimum gap kept.
// [R24] Skip bit bypasses the message but keeps delay.
// [R25] End-of-list bit halts and raises high-priority interrupt.
// [R26] Poll interrupt when any mask bit also set in status.
// [R27] DMA by request and grant; request held across a burst.
// [R28] Serial coding lives in a separate codec module.
module bcms_sequencer
  import bcms_pkg::*;
#(
  parameter int unsigned STEP_CYC = `BCMS_STEP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic START,
  input wire logic CUR_BLK_LD,
  input wire logic [15:0] CUR_BLK_IN,
  input wire logic LOG_PTR_LD,
  input wire logic [15:0] LOG_PTR_IN,
  input wire logic [1:0] HP_EN,
  input wire logic [2:0] HP_CLR,
  input wire logic [2:0] STD_EN,
  input wire logic STD_LVL_EN,
  input wire logic [15:0] POLL_COMPARE_MASK,
  input wire logic RETRY_EN,
  input wire logic RETRY_ALT,
  input wire logic [1:0] RETRY_LIMIT,
  input wire logic DMA_GNT,
  input wire logic DMA_ACK,
  input wire logic [15:0] DMA_RDATA,
  input wire logic RX_BIT,
  input wire logic RX_ACT,
  output bcms_dma_s DMA_OUT,
  output logic TX_BIT,
  output logic TX_EN,
  output logic BUS_SEL,
  output logic BUSY,
  output logic [15:0] CUR_BLK,
  output logic [15:0] LOG_PTR,
  output logic [2:0] HP_STATUS,
  output logic HIGH_PRIORITY_IRQ_N,
  output logic STANDARD_IRQ_PULSE_N,
  output logic STANDARD_IRQ_LEVEL_N
);
  bcms_seq_s s_r, n;
  bcms_rxw_s rx;
  bcms_state_e dec_st;
  logic tx_done, acc_done, dma_st, need_f, tx_fin, rp, bad2;
  logic rtrt, end_of_list_flag, nd_fetch;
  logic [5:0] wc;
  logic [4:0] exp_addr;
  logic [15:0] a_addr, a_wd;
  logic a_we;
  logic [2:0] hp_set;

  // Serial side kept apart so framing can change alone [R28]
  bcms_codec u_codec (
    .clk(CLK_SYS),
    .srst(SRST),
    .tx_start(s_r.tx_start),
    .tx_word(s_r.tx_word),
    .tx_cmd(s_r.tx_cmd),
    .rx_bit(RX_BIT),
    .rx_act(RX_ACT),
    .tx_bit(TX_BIT),
    .tx_en(TX_EN),
    .tx_done(tx_done),
    .rx(rx)
  );

  assign rtrt = s_r.ctl[`BCMS_CTL_RTRT];
  assign end_of_list_flag = s_r.ctl[`BCMS_CTL_EOL];
  assign wc = (s_r.cmd1[4:0] == 5'h00) ? 6'h20 : {1'b0, s_r.cmd1[4:0]};
  assign exp_addr = (rtrt && !s_r.phase) ? s_r.cmd2[15:11]
                                         : s_r.cmd1[15:11];
  assign tx_fin = s_r.txw && tx_done;
  assign acc_done = s_r.dma.stb && DMA_ACK;
  assign need_f = (s_r.fcnt < wc) && !s_r.buf_vld;
  assign bad2 = s_r.cmd1[`BCMS_CMD_TR] || !DMA_RDATA[`BCMS_CMD_TR] ||
                (s_r.cmd1[15:11] == DMA_RDATA[15:11]) ||
                (s_r.cmd1[4:0] != DMA_RDATA[4:0]); // [R2]
  assign rp = s_r.err && s_r.ctl[`BCMS_CTL_RETRY] && RETRY_EN &&
              (s_r.rtry <= {1'b0, RETRY_LIMIT});

  function automatic logic is_dma(input bcms_state_e st);
    is_dma = (st == S_F_CTL) || (st == S_F_CMD1) || (st == S_F_PTR) ||
             (st == S_F_CMD2) || (st == S_W_STAT) || (st == S_W_DATA) ||
             (st == S_LOG_ISW) || (st == S_LOG_PTR) ||
             (st == S_LOG_TAIL) || (st == S_WB_CTL) || (st == S_RD_TAIL);
  endfunction : is_dma

  // Address and data of the access that belongs to each state
  always_comb begin
    a_addr = s_r.cur_blk + `BCMS_OFS_CTL;
    a_wd = 16'h0000;
    a_we = 1'b0;
    case (s_r.state)
      S_F_CMD1: a_addr = s_r.cur_blk + `BCMS_OFS_CMD1; // [R4]
      S_F_PTR: a_addr = s_r.cur_blk + `BCMS_OFS_PTR;
      S_F_CMD2: a_addr = s_r.cur_blk + `BCMS_OFS_CMD2; // [R8]
      S_TX_DATA: a_addr = s_r.dptr; // [R5]
      S_W_STAT: begin
        a_addr = s_r.cur_blk + (s_r.phase ? `BCMS_OFS_STS2
                                          : `BCMS_OFS_STS1); // [R6] [R10]
        a_wd = s_r.rxd;
        a_we = 1'b1;
      end
      S_W_DATA: begin
        a_addr = s_r.dptr; // [R7]
        a_wd = s_r.rxd;
        a_we = 1'b1;
      end
      S_LOG_ISW: begin
        a_addr = s_r.log_ptr; // [R12]
        a_wd = {13'h0000, s_r.isw};
        a_we = 1'b1;
      end
      S_LOG_PTR: begin
        a_addr = s_r.log_ptr + 16'h0001;
        a_wd = s_r.cur_blk;
        a_we = 1'b1;
      end
      S_LOG_TAIL: a_addr = s_r.log_ptr + 16'h0002;
      S_WB_CTL: begin
        a_wd = s_r.ctl;
        a_wd[`BCMS_CTL_ME] = 1'b1; // [R15] [R20]
        a_we = 1'b1;
      end
      S_RD_TAIL: a_addr = s_r.cur_blk + `BCMS_OFS_TAIL;
      default: a_addr = s_r.cur_blk + `BCMS_OFS_CTL;
    endcase
  end

  // Where a finished message goes next
  always_comb begin
    if (s_r.retry) begin
      dec_st = S_F_CTL; // [R13]
    end else if (end_of_list_flag) begin
      dec_st = s_r.me ? S_WB_CTL : S_IDLE; // [R16]
    end else begin
      dec_st = S_DELAY;
    end
  end

  always_comb begin
    n = s_r;
    hp_set = 3'h0;
    nd_fetch = 1'b0;
    n.tx_start = 1'b0;
    n.pls_n = 1'b1;
    dma_st = is_dma(s_r.state) ||
             ((s_r.state == S_TX_DATA) && need_f);
    if (s_r.dma.req && DMA_GNT && !s_r.dma.stb && dma_st) begin
      n.dma.stb = 1'b1; // [R27]
      n.dma.addr = a_addr;
      n.dma.we = a_we;
      n.dma.wdata = a_wd;
    end
    if (acc_done) begin
      n.dma.stb = 1'b0;
    end
    if (s_r.dly != 18'h00000) begin
      n.dly = s_r.dly - 18'h00001;
    end
    if (s_r.gap != 8'h00) begin
      n.gap = s_r.gap - 8'h01;
    end
    n.tmo = ((s_r.state == S_RX_STAT || s_r.state == S_RX_DATA) &&
             !RX_ACT) ? s_r.tmo + 10'h001 : 10'h000;
    case (s_r.state)
      S_IDLE: begin
        n.busy = 1'b0;
        if (CUR_BLK_LD) begin
          n.cur_blk = CUR_BLK_IN;
        end
        if (LOG_PTR_LD) begin
          n.log_ptr = LOG_PTR_IN;
        end
        if (START) begin
          n.state = S_F_CTL; // [R3]
          n.busy = 1'b1;
          n.retry = 1'b0;
          n.rtry = 3'h0;
          n.me = 1'b0;
        end
      end
      S_F_CTL: if (acc_done) begin
        n.ctl = DMA_RDATA;
        n.state = S_F_CMD1; // [R4]
      end
      S_F_CMD1: if (acc_done) begin
        n.cmd1 = DMA_RDATA;
        n.state = S_F_PTR;
      end
      S_F_PTR: if (acc_done) begin
        n.dptr = DMA_RDATA; // [R21]
        n.err = 1'b0;
        n.phase = 1'b0;
        n.cnt = 6'h00;
        n.fcnt = 6'h00;
        n.buf_vld = 1'b0;
        n.isw = 3'h0;
        if (!s_r.retry) begin
          n.dly = 18'(s_r.ctl[7:0] * STEP_CYC); // [R18] [R23]
        end
        n.state = s_r.ctl[`BCMS_CTL_SKIP] ? S_POST : S_TX_CMD1; // [R24]
      end
      S_TX_CMD1, S_TX_CMD2: begin
        if (!s_r.txw) begin
          n.tx_start = 1'b1;
          n.tx_cmd = 1'b1;
          n.tx_word = (s_r.state == S_TX_CMD2) ? s_r.cmd2 : s_r.cmd1;
          n.txw = 1'b1;
        end else if (tx_fin) begin
          n.txw = 1'b0;
          if (s_r.state == S_TX_CMD2 || s_r.cmd1[`BCMS_CMD_TR]) begin
            n.state = S_RX_STAT;
          end else if (rtrt) begin
            n.state = S_F_CMD2; // [R8]
          end else begin
            n.state = S_TX_DATA;
          end
        end
      end
      S_F_CMD2: if (acc_done) begin
        n.cmd2 = DMA_RDATA;
        n.err = bad2; // [R2]
        n.state = bad2 ? S_POST : S_TX_CMD2;
      end
      S_TX_DATA: begin
        if (acc_done) begin
          n.buf_w = DMA_RDATA; // [R19]
          n.buf_vld = 1'b1;
          n.dptr = s_r.dptr + 16'h0001; // [R5]
          n.fcnt = s_r.fcnt + 6'h01;
        end
        if (s_r.buf_vld && !s_r.txw) begin
          n.tx_start = 1'b1;
          n.tx_cmd = 1'b0;
          n.tx_word = s_r.buf_w;
          n.txw = 1'b1;
          n.buf_vld = 1'b0;
        end else if (tx_fin) begin
          n.txw = 1'b0;
          n.cnt = s_r.cnt + 6'h01;
          if (s_r.cnt + 6'h01 == wc) begin
            n.state = S_RX_STAT;
          end
        end
      end
      S_RX_STAT: if (rx.valid) begin
        n.rxd = rx.word;
        n.err = rx.err || !rx.cmd_sync || rx.word[`BCMS_STS_ME] ||
                (rx.word[15:11] != exp_addr); // [R1] [R2]
        if (s_r.ctl[`BCMS_CTL_POLL] &&
            ((rx.word & POLL_COMPARE_MASK) != 16'h0000)) begin
          n.isw[`BCMS_ISW_POLL] = STD_EN[`BCMS_ISW_POLL]; // [R26]
        end
        n.state = S_W_STAT;
      end else if (s_r.tmo == 10'(`BCMS_TMO_CYC)) begin
        n.err = 1'b1; // [R2]
        n.state = S_POST;
      end
      S_W_STAT: if (acc_done) begin
        n.cnt = 6'h00;
        if (s_r.err || s_r.phase) begin
          n.state = S_POST;
        end else if (rtrt || s_r.cmd1[`BCMS_CMD_TR]) begin
          n.state = S_RX_DATA; // [R7]
        end else begin
          n.state = S_POST;
        end
      end
      S_RX_DATA: if (rx.valid) begin
        n.rxd = rx.word;
        if (rx.err || rx.cmd_sync) begin
          n.err = 1'b1; // [R2]
          n.state = S_POST;
        end else if (!rtrt || s_r.ctl[`BCMS_CTL_MON]) begin
          n.state = S_W_DATA; // [R9]
        end else begin
          n.cnt = s_r.cnt + 6'h01;
          nd_fetch = (s_r.cnt + 6'h01 == wc);
        end
      end else if (s_r.tmo == 10'(`BCMS_TMO_CYC)) begin
        n.err = 1'b1;
        n.state = S_POST;
      end
      S_W_DATA: if (acc_done) begin
        n.dptr = s_r.dptr + 16'h0001; // [R7]
        n.cnt = s_r.cnt + 6'h01;
        nd_fetch = (s_r.cnt + 6'h01 == wc);
        n.state = S_RX_DATA;
      end
      S_POST: begin
        n.gap = 8'(`BCMS_GAP_CYC); // [R23]
        n.me = s_r.me || s_r.err; // [R20]
        n.retry = rp;
        if (rp) begin
          n.rtry = s_r.rtry + 3'h1;
          n.bus = s_r.bus ^ RETRY_ALT; // [R21]
        end
        hp_set[`BCMS_HP_ME] = s_r.err && HP_EN[`BCMS_HP_ME]; // [R11]
        hp_set[`BCMS_HP_EOL] = end_of_list_flag && !rp &&
                               HP_EN[`BCMS_HP_EOL]; // [R22] [R25]
        n.isw[`BCMS_ISW_INTC] = s_r.ctl[`BCMS_CTL_INTC] &&
                                STD_EN[`BCMS_ISW_INTC];
        n.isw[`BCMS_ISW_ME] = s_r.err && STD_EN[`BCMS_ISW_ME];
        n.state = S_HP_HOLD;
      end
      S_HP_HOLD: if (!s_r.hp[`BCMS_HP_ME]) begin
        n.state = (s_r.isw != 3'h0) ? S_LOG_ISW : dec_st; // [R11]
      end
      S_LOG_ISW: if (acc_done) begin
        n.state = S_LOG_PTR; // [R12]
      end
      S_LOG_PTR: if (acc_done) begin
        n.state = S_LOG_TAIL;
      end
      S_LOG_TAIL: if (acc_done) begin
        n.log_ptr = DMA_RDATA; // [R12]
        n.pls_n = 1'b0;
        hp_set[`BCMS_HP_STD] = STD_LVL_EN;
        n.isw = 3'h0;
        n.state = dec_st;
      end
      S_DELAY: if (s_r.dly == 18'h00000 && s_r.gap == 8'h00) begin
        n.state = s_r.me ? S_WB_CTL : S_RD_TAIL; // [R15] [R18]
      end
      S_WB_CTL: if (acc_done) begin
        n.state = end_of_list_flag ? S_IDLE : S_RD_TAIL; // [R15]
      end
      S_RD_TAIL: if (acc_done) begin
        n.cur_blk = DMA_RDATA; // [R17]
        n.me = 1'b0;
        n.rtry = 3'h0;
        n.state = S_DMA_HOLD; // [R14]
      end
      S_DMA_HOLD: n.state = S_F_CTL; // [R14]
      default: n.state = S_IDLE;
    endcase
    if (nd_fetch) begin
      n.phase = rtrt;
      n.state = rtrt ? S_RX_STAT : S_POST; // [R10]
    end
    // A new event wins over a clear arriving in the same cycle
    n.hp = hp_set | (s_r.hp & ~HP_CLR);
    n.hp_n = ~|n.hp[`BCMS_HP_ME:`BCMS_HP_EOL];
    n.lvl_n = ~n.hp[`BCMS_HP_STD];
    // Request spans the whole burst so the arbiter cannot cut in [R27]
    n.dma.req = is_dma(n.state) || (n.state == S_DMA_HOLD) ||
                ((n.state == S_TX_DATA) && (n.fcnt < wc) && !n.buf_vld);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_r <= '0;
      s_r.hp_n <= 1'b1;
      s_r.pls_n <= 1'b1;
      s_r.lvl_n <= 1'b1;
    end else begin
      s_r <= n;
    end
  end

  assign DMA_OUT = s_r.dma;
  assign BUS_SEL = s_r.bus;
  assign BUSY = s_r.busy;
  assign CUR_BLK = s_r.cur_blk;
  assign LOG_PTR = s_r.log_ptr;
  assign HP_STATUS = s_r.hp;
  assign HIGH_PRIORITY_IRQ_N = s_r.hp_n;
  assign STANDARD_IRQ_PULSE_N = s_r.pls_n;
  assign STANDARD_IRQ_LEVEL_N = s_r.lvl_n;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  AST_STB_IN_REQ: assert property (s_r.dma.stb |-> s_r.dma.req) // [R27]
    else $error("strobe without request");
  AST_FETCH_ORDER: assert property ( // [R4]
    s_r.state == S_F_CTL && acc_done |=> s_r.state == S_F_CMD1)
    else $error("control word not followed by command fetch");
  AST_CMD1_ADDR: assert property ( // [R4]
    s_r.state == S_F_CMD1 && s_r.dma.stb |->
    s_r.dma.addr == s_r.cur_blk + `BCMS_OFS_CMD1 && !s_r.dma.we)
    else $error("command one fetched from wrong offset");
  AST_STAT_ADDR: assert property ( // [R6]
    s_r.state == S_W_STAT && s_r.dma.stb |-> s_r.dma.we &&
    s_r.dma.addr == s_r.cur_blk + (s_r.phase ? `BCMS_OFS_STS2
                                             : `BCMS_OFS_STS1))
    else $error("status stored at wrong offset");
  AST_NO_MON_DMA: assert property ( // [R9]
    s_r.state == S_W_DATA |-> !rtrt || s_r.ctl[`BCMS_CTL_MON])
    else $error("unmonitored transfer data written");
  AST_ADDR_MISMATCH: assert property ( // [R1]
    s_r.state == S_RX_STAT && rx.valid && rx.word[15:11] != exp_addr
    |=> s_r.err)
    else $error("address mismatch not flagged");
  AST_TIMEOUT: assert property ( // [R2]
    s_r.state == S_RX_STAT && !rx.valid &&
    s_r.tmo == 10'(`BCMS_TMO_CYC) |=> s_r.err && s_r.state == S_POST)
    else $error("timeout not flagged");
  AST_ME_STICKY: assert property ( // [R20]
    s_r.me && s_r.state != S_RD_TAIL && s_r.state != S_IDLE |=> s_r.me)
    else $error("message error flag lost");
  AST_ME_HOLD: assert property ( // [R11]
    s_r.state == S_HP_HOLD && s_r.hp[`BCMS_HP_ME] |=>
    s_r.state == S_HP_HOLD)
    else $error("left hold before acknowledge");
  AST_TAIL_HOLD: assert property ( // [R14]
    s_r.state == S_RD_TAIL && acc_done |=>
    s_r.state == S_DMA_HOLD && s_r.dma.req && !s_r.dma.stb ##1
    s_r.state == S_F_CTL && s_r.dma.req)
    else $error("hold cycle missing in burst");
  AST_TAIL_LOAD: assert property ( // [R17]
    s_r.state == S_RD_TAIL && acc_done |=> s_r.cur_blk == $past(DMA_RDATA))
    else $error("tail pointer not loaded");
  AST_WB_FIRST: assert property ( // [R15]
    s_r.state == S_RD_TAIL && $past(s_r.state) != S_RD_TAIL |->
    $past(s_r.state) == S_WB_CTL || !s_r.me)
    else $error("control word not written back first");
  AST_NO_EOL_NEXT: assert property (s_r.state == S_RD_TAIL |-> !end_of_list_flag) // [R16]
    else $error("next block fetched after end of list");
  AST_STD_PULSE: assert property ( // [R12]
    s_r.state == S_LOG_TAIL && acc_done |=>
    !STANDARD_IRQ_PULSE_N ##1 STANDARD_IRQ_PULSE_N)
    else $error("standard pulse malformed");
  AST_DELAY_LOAD: assert property ( // [R18]
    s_r.state == S_F_PTR && acc_done && !s_r.retry |=>
    s_r.dly == 18'($past(s_r.ctl[7:0]) * STEP_CYC))
    else $error("delay timer not started with message");

  COV_EOL_HALT: cover property (s_r.state == S_WB_CTL ##1
                                s_r.state == S_IDLE);
  COV_RETRY: cover property (s_r.state == S_HP_HOLD && s_r.retry ##1
                             s_r.state == S_F_CTL);
  COV_RTRT_MON: cover property (s_r.state == S_W_STAT && s_r.phase);
  COV_LOG: cover property (s_r.state == S_LOG_TAIL && acc_done);
endmodule : bcms_sequencer

// *** bcms_rt_model.sv ***
`timescale 1ns/1ns
module bcms_rt_model #(
  parameter int NW = 2
) (
  input wire logic clk,
  input wire logic tx_en,
  input wire logic [15:0] stat,
  output logic rx_bit,
  output logic rx_act
);
  logic [19:0] w;
  int i;
  initial begin
    rx_bit = 1'b0;
    rx_act = 1'b0;
    forever begin
      // Answers only after the whole command and data have gone out
      repeat (NW) begin
        @(posedge tx_en);
        @(negedge tx_en);
      end
      repeat (200) @(posedge clk);
      w = {3'h7, stat, ~^stat};
      rx_act <= 1'b1;
      for (i = 19; i >= 0; i--) begin
        rx_bit <= w[i];
        repeat (50) @(posedge clk);
      end
      rx_act <= 1'b0;
      // Idle line must not look like a held bit
      rx_bit <= ~w[0];
    end
  end
endmodule : bcms_rt_model

// *** tb_bcms_sequencer.sv ***
`timescale 1ns/1ns
module tb_bcms_sequencer;
  import bcms_pkg::*;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic START = 1'b0, CUR_BLK_LD = 1'b0, LOG_PTR_LD = 1'b0;
  logic [1:0] HP_EN = 2'h1, RETRY_LIMIT = 2'h0;
  logic [2:0] HP_CLR = 3'h0, STD_EN = 3'h0, HP_STATUS;
  logic STD_LVL_EN = 1'b0, RETRY_EN = 1'b0, RETRY_ALT = 1'b0;
  logic [15:0] CUR_BLK_IN = 16'h0010, LOG_PTR_IN = 16'h0080;
  logic [15:0] POLL_COMPARE_MASK = 16'h0000, DMA_RDATA = 16'h0000;
  logic [15:0] CUR_BLK, LOG_PTR, stat;
  logic DMA_GNT = 1'b0, DMA_ACK = 1'b0, RX_BIT, RX_ACT, TX_BIT, TX_EN;
  logic BUS_SEL, BUSY, bad = 1'b0;
  logic HIGH_PRIORITY_IRQ_N, STANDARD_IRQ_PULSE_N, STANDARD_IRQ_LEVEL_N;
  bcms_dma_s DMA_OUT;
  logic [15:0] mem [256];
  logic [15:0] la [64];
  logic [15:0] e1 [11] = '{16'h0011, 16'h0012, 16'h0014, 16'h0040,
    16'h8015, 16'h0017, 16'h0021, 16'h0022, 16'h0024, 16'h0041, 16'h8025};
  int n = 0, errors = 0, n_checks = 0;
  always #10 CLK_SYS = ~CLK_SYS;
  assign stat = bad ? 16'h3000 : 16'h2800;
  bcms_sequencer #(.STEP_CYC(4)) u_dut (.*);
  bcms_rt_model #(.NW(2)) u_rt (.clk(CLK_SYS), .tx_en(TX_EN),
    .stat(stat), .rx_bit(RX_BIT), .rx_act(RX_ACT));
  // Memory side grants every request and answers one cycle later
  always @(posedge CLK_SYS) begin
    DMA_GNT <= DMA_OUT.req;
    DMA_ACK <= 1'b0;
    if (DMA_OUT.stb && !DMA_ACK) begin
      DMA_ACK <= 1'b1;
      DMA_RDATA <= mem[DMA_OUT.addr[7:0]];
      if (DMA_OUT.we) mem[DMA_OUT.addr[7:0]] <= DMA_OUT.wdata;
      la[n] <= {DMA_OUT.we, 7'h00, DMA_OUT.addr[7:0]};
      n <= n + 1;
      if (DMA_OUT.we && DMA_OUT.addr == 16'h0015) bad <= 1'b0;
    end else begin
      DMA_RDATA <= ~DMA_RDATA;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic b);
    int k;
    mem[8'h11] = 16'h0000;
    mem[8'h12] = 16'h2821;
    mem[8'h14] = 16'h0040;
    mem[8'h17] = 16'h0020;
    mem[8'h21] = 16'h0400;
    mem[8'h22] = 16'h2821;
    mem[8'h24] = 16'h0041;
    bad = b;
    n = 0;
    @(posedge CLK_SYS) CUR_BLK_LD <= 1'b1;
    @(posedge CLK_SYS) CUR_BLK_LD <= 1'b0;
    @(posedge CLK_SYS) START <= 1'b1;
    @(posedge CLK_SYS) START <= 1'b0;
    #1;
    k = 0;
    while (BUSY !== 1'b0 && k < 20000) begin
      @(posedge CLK_SYS);
      k++;
    end
    #1;
    chk(16'(BUSY), 16'h0000);
    for (k = 0; k < 11; k++) begin
      chk(la[(b && k > 4) ? k + 1 : k], e1[k]);
    end
    if (b) chk(la[5], 16'h8011);
    chk(16'(mem[8'h11][15]), 16'(b));
    chk(mem[8'h15], b ? 16'h3000 : 16'h2800);
    chk(CUR_BLK, 16'h0020);
    chk(16'(HIGH_PRIORITY_IRQ_N), 16'h0000);
    @(posedge CLK_SYS) HP_CLR <= 3'h1;
    @(posedge CLK_SYS) HP_CLR <= 3'h0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(16'(HIGH_PRIORITY_IRQ_N), 16'h0001);
    $display("Test %0d done", b);
  endtask : run
  task automatic test_done;
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    mem[8'h40] = 16'hbeef;
    mem[8'h41] = 16'h1234;
    repeat (16) @(posedge CLK_SYS);
    SRST <= 1'b0;
    run(1'b0);
    run(1'b1);
    test_done;
  end
  initial begin
    #2000000;
    errors++;
    test_done;
  end
endmodule : tb_bcms_sequencer
